/* File: src/tuf_trace_ctl.sv */
`timescale 1ns/1ps
module tuf_trace_ctl #(
  parameter int DATA_W = tuf_pkg::DATA_W,
  parameter int BUF_DEPTH = tuf_pkg::BUF_DEPTH,
  parameter int EVT_W = tuf_pkg::EVT_W
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // enable controls
  input wire logic PROGRAM_ENABLE_BIT_I,
  input wire logic OS_LOCK_I,
  input wire logic LOWPOWER_OVERRIDE_BIT_I,
  // processor status pins, asynchronous
  input wire logic PE_WAIT_EVENT_INSTR_I,
  input wire logic PE_WAIT_INTERRUPT_INSTR_I,
  input wire logic PE_DEBUG_I,
  // barrier and trace buffer feature, same clock as the unit
  input wire logic TRACE_SYNC_BARRIER_I,
  input wire logic TRACE_PROHIBITED_I,
  input wire logic TRACE_BUFFER_FEATURE_I,
  input wire logic TRACE_BUFFER_ENABLE_I,
  // packet encoder side
  input wire logic ENC_VALID_I,
  input wire logic [DATA_W-1:0] ENC_DATA_I,
  input wire logic ENC_BUSY_I,
  input wire logic OVF_PENDING_I,
  input wire logic EVENT_ELEM_PENDING_I,
  output logic ENC_READY_O,
  output logic ENC_FLUSH_O,
  output logic GEN_ENABLE_O,
  // resources and external events
  input wire logic RES_BUSY_I,
  input wire logic [EVT_W-1:0] EVENT_I,
  output logic RES_RUN_O,
  output logic [EVT_W-1:0] EXTERNAL_EVENT_OUTPUT_O,
  // capture side byte stream and flush
  input wire logic TRC_READY_I,
  input wire logic FLUSH_REQ_I,
  output logic TRC_VALID_O,
  output logic [DATA_W-1:0] TRC_DATA_O,
  output logic FLUSH_ACK_O,
  // status
  output logic ENABLED_O,
  output logic STATUS_IDLE_FLAG_O,
  output logic MODEL_STABLE_FLAG_O,
  output logic LOWPOWER_O,
  output logic LP_HOLDOFF_O
);
  localparam int CNT_W = $clog2(BUF_DEPTH + 1);

  logic [tuf_pkg::PIN_W-1:0] pe_pins;
  logic pe_wfe;
  logic pe_wfi;
  logic pe_dbg;
  logic en_now;
  logic en_fall;
  logic enabled_ff;
  logic lp_ff;
  logic nxt_lp;
  logic lp_ok;
  logic lp_ready;
  logic int_pend_ff;
  logic int_trig;
  logic tsb_trig;
  logic need_ack_ff;
  logic out_vld_ff;
  logic [DATA_W-1:0] out_data_ff;
  logic [DATA_W-1:0] buf_data;
  logic [CNT_W-1:0] buf_cnt;
  logic [CNT_W-1:0] nxt_cnt;
  logic push;
  logic pop;
  logic drained;
  tuf_pkg::tuf_flush_st_t state_ff;
  tuf_pkg::tuf_flush_st_t nxt_state;

  // pe power and debug state arrive from another domain
  tuf_sync2 #(
    .WIDTH(tuf_pkg::PIN_W),
    .STAGES(tuf_pkg::SYNC_STAGES)
  ) u_pin_sync (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i({PE_WAIT_EVENT_INSTR_I, PE_WAIT_INTERRUPT_INSTR_I, PE_DEBUG_I}),
    .q_o(pe_pins)
  );

  assign pe_wfe = pe_pins[tuf_pkg::PIN_WFE];
  assign pe_wfi = pe_pins[tuf_pkg::PIN_WFI];
  assign pe_dbg = pe_pins[tuf_pkg::PIN_DEBUG];

  // enable decode; low power plays no part, so enabled survives it
  assign en_now = PROGRAM_ENABLE_BIT_I & ~OS_LOCK_I;
  assign en_fall = enabled_ff & ~en_now;

  // drain buffer between encoder and capture port
  tuf_byte_buf #(
    .WIDTH(DATA_W),
    .DEPTH(BUF_DEPTH),
    .CNT_W(CNT_W)
  ) u_buf (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .push_i(push),
    .data_i(ENC_DATA_I),
    .pop_i(pop),
    .data_o(buf_data),
    .count_o(buf_cnt)
  );

  // draining keeps running after disable so nothing is stranded
  assign push = ENC_VALID_I & ENC_READY_O;
  assign pop = (buf_cnt != '0) & (~out_vld_ff | TRC_READY_I);
  assign nxt_cnt = buf_cnt + CNT_W'(push) - CNT_W'(pop);
  assign drained = (buf_cnt == '0) & ~out_vld_ff & ~ENC_VALID_I;

  // output register; a byte stands until the capture side takes it
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      out_vld_ff <= 1'b0;
      out_data_ff <= '0;
    end else if (pop) begin
      out_vld_ff <= 1'b1;
      out_data_ff <= buf_data;
    end else if (TRC_READY_I) begin
      out_vld_ff <= 1'b0;
    end
  end

  assign TRC_VALID_O = out_vld_ff;
  assign TRC_DATA_O = out_data_ff;

  // ready follows exact next occupancy, so a push can never overrun
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ENC_READY_O <= 1'b0;
    end else begin
      ENC_READY_O <= (nxt_cnt < CNT_W'(BUF_DEPTH));
    end
  end

  // low power permission and readiness; paused resources mean no event in flight
  assign lp_ok = pe_wfe | pe_wfi | pe_dbg | ~en_now;
  assign lp_ready = lp_ok & ~LOWPOWER_OVERRIDE_BIT_I & ~RES_BUSY_I & ~ENC_BUSY_I
                    & drained & (state_ff == tuf_pkg::TUF_FL_IDLE);

  // stay in low power only while it stays permitted
  always_comb begin
    if (lp_ff) begin
      nxt_lp = lp_ok & ~LOWPOWER_OVERRIDE_BIT_I;
    end else begin
      nxt_lp = lp_ready;
    end
  end

  // low power state
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      lp_ff <= tuf_pkg::RST_LOWPOWER;
    end else begin
      lp_ff <= nxt_lp;
    end
  end

  assign LOWPOWER_O = lp_ff;

  // generation, resources and events; none run while disabled or in low power
  // resources are only paused, never cleared, so re-enable resumes them
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      enabled_ff <= tuf_pkg::RST_ENABLED;
      ENABLED_O <= tuf_pkg::RST_ENABLED;
      GEN_ENABLE_O <= 1'b0;
      RES_RUN_O <= 1'b0;
      EXTERNAL_EVENT_OUTPUT_O <= '0;
    end else begin
      enabled_ff <= en_now;
      ENABLED_O <= en_now;
      GEN_ENABLE_O <= en_now & ~nxt_lp;
      RES_RUN_O <= en_now & ~nxt_lp;
      EXTERNAL_EVENT_OUTPUT_O <= (en_now & ~nxt_lp) ? EVENT_I : '0;
    end
  end

  // internal flush causes; a new cause beats the clear of an earlier one
  assign tsb_trig = TRACE_SYNC_BARRIER_I & TRACE_PROHIBITED_I
                    & TRACE_BUFFER_FEATURE_I & TRACE_BUFFER_ENABLE_I;
  assign int_trig = en_fall | tsb_trig;

  // pending internal flush; a cause seen while idle starts the flush at once,
  // so only causes that arrive mid flush are kept, else each would run twice
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      int_pend_ff <= 1'b0;
    end else if (int_trig & (state_ff != tuf_pkg::TUF_FL_IDLE)) begin
      int_pend_ff <= 1'b1;
    end else if (state_ff == tuf_pkg::TUF_FL_IDLE) begin
      int_pend_ff <= 1'b0;
    end
  end

  // flush sequencer: encode, drain, acknowledge if the capture side asked
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      tuf_pkg::TUF_FL_IDLE: begin
        if (FLUSH_REQ_I | int_pend_ff | int_trig) begin
          nxt_state = tuf_pkg::TUF_FL_ENCODE;
        end
      end
      tuf_pkg::TUF_FL_ENCODE: begin
        // overflow element and partial packets must be out of the encoder
        if (~ENC_BUSY_I & ~OVF_PENDING_I) begin
          nxt_state = tuf_pkg::TUF_FL_DRAIN;
        end
      end
      tuf_pkg::TUF_FL_DRAIN: begin
        // a halting cause must see generation off before the answer
        if (drained & ~ENC_BUSY_I & (en_now | ~GEN_ENABLE_O)) begin
          nxt_state = need_ack_ff ? tuf_pkg::TUF_FL_ACK : tuf_pkg::TUF_FL_IDLE;
        end
      end
      tuf_pkg::TUF_FL_ACK: begin
        if (~FLUSH_REQ_I) begin
          nxt_state = tuf_pkg::TUF_FL_IDLE;
        end
      end
    endcase
  end

  // sequencer state and whether the capture side waits for an answer
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_ff <= tuf_pkg::TUF_FL_IDLE;
      need_ack_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == tuf_pkg::TUF_FL_IDLE) begin
        need_ack_ff <= FLUSH_REQ_I;
      end else if (FLUSH_REQ_I) begin
        need_ack_ff <= 1'b1;
      end
    end
  end

  // flush handshake outputs, registered from the next state
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ENC_FLUSH_O <= 1'b0;
      FLUSH_ACK_O <= 1'b0;
    end else begin
      ENC_FLUSH_O <= (nxt_state == tuf_pkg::TUF_FL_ENCODE);
      FLUSH_ACK_O <= (nxt_state == tuf_pkg::TUF_FL_ACK);
    end
  end

  // status flags; idle waits for events, encoder, buffer and flush to finish
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      STATUS_IDLE_FLAG_O <= tuf_pkg::RST_IDLE;
      MODEL_STABLE_FLAG_O <= tuf_pkg::RST_STABLE;
    end else begin
      STATUS_IDLE_FLAG_O <= ~en_now & ~GEN_ENABLE_O & drained & ~ENC_BUSY_I
                            & ~EVENT_ELEM_PENDING_I & ~int_pend_ff
                            & (state_ff == tuf_pkg::TUF_FL_IDLE);
      MODEL_STABLE_FLAG_O <= ~en_now & ~RES_RUN_O & ~RES_BUSY_I;
    end
  end

  // ask the pe to wait only while enabled, not overridden and not ready
  // limitation: the pe may ignore the hold-off; the unit then follows it late
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      LP_HOLDOFF_O <= 1'b0;
    end else begin
      LP_HOLDOFF_O <= en_now & ~LOWPOWER_OVERRIDE_BIT_I
                      & (pe_wfe | pe_wfi) & ~lp_ready & ~lp_ff;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_enable_decode: assert property (
    ##1 ENABLED_O == $past(PROGRAM_ENABLE_BIT_I & ~OS_LOCK_I))
    else $error("enabled status does not follow enable and lock");
  a_disabled_quiet: assert property (
    !ENABLED_O |-> !GEN_ENABLE_O && !RES_RUN_O && EXTERNAL_EVENT_OUTPUT_O == '0)
    else $error("trace or resources active while disabled");
  a_idle_needs_empty: assert property (
    $rose(STATUS_IDLE_FLAG_O) |-> $past(buf_cnt == '0 && !out_vld_ff && !EVENT_ELEM_PENDING_I))
    else $error("idle shown with data or events still held");
  a_ovf_before_drain: assert property (
    state_ff == tuf_pkg::TUF_FL_ENCODE && OVF_PENDING_I |=> state_ff != tuf_pkg::TUF_FL_DRAIN)
    else $error("flush drained before the overflow element");
  a_ack_after_drain: assert property (
    $rose(FLUSH_ACK_O) |-> !TRC_VALID_O && buf_cnt == '0)
    else $error("acknowledge raised with bytes outstanding");
  a_ack_held: assert property (
    FLUSH_ACK_O && FLUSH_REQ_I |=> FLUSH_ACK_O)
    else $error("acknowledge dropped while request still high");
  a_barrier_flush: assert property (
    state_ff == tuf_pkg::TUF_FL_IDLE && tsb_trig |=> ENC_FLUSH_O)
    else $error("barrier in prohibited code did not flush");
  a_lp_permitted: assert property (
    LOWPOWER_O && !LOWPOWER_OVERRIDE_BIT_I && !lp_ok |=> !LOWPOWER_O)
    else $error("low power held without a permitted cause");
  a_lp_quiet: assert property (
    LOWPOWER_O |-> !GEN_ENABLE_O && EXTERNAL_EVENT_OUTPUT_O == '0)
    else $error("trace or external outputs active in low power");
  a_no_holdoff: assert property (
    !en_now || LOWPOWER_OVERRIDE_BIT_I |=> !LP_HOLDOFF_O)
    else $error("hold-off raised while disabled or overridden");
  a_override_awake: assert property (
    LOWPOWER_OVERRIDE_BIT_I [*2] |-> !LOWPOWER_O)
    else $error("low power entered under override");

  c_flush_ack: cover property ($rose(FLUSH_ACK_O) ##[1:20] !FLUSH_ACK_O);
  c_lp_entry: cover property (ENABLED_O && $rose(LOWPOWER_O));
  c_disable_idle: cover property ($fell(ENABLED_O) ##[1:50] $rose(STATUS_IDLE_FLAG_O));
endmodule

/* File: src/tuf_pkg.sv */
package tuf_pkg;
  // byte lane width of the trace stream
  localparam int DATA_W = 8;
  // depth of the drain buffer in bytes
  localparam int BUF_DEPTH = 8;
  // number of external event outputs
  localparam int EVT_W = 4;
  // synchroniser length for pe status pins
  localparam int SYNC_STAGES = 2;
  // pe status pin positions after synchronising
  localparam int PIN_DEBUG = 0;
  localparam int PIN_WFI = 1;
  localparam int PIN_WFE = 2;
  localparam int PIN_W = 3;
  // reset values of control and status
  localparam logic RST_ENABLED = 1'b0;
  localparam logic RST_IDLE = 1'b1;
  localparam logic RST_STABLE = 1'b1;
  localparam logic RST_LOWPOWER = 1'b0;

  // flush sequencer states
  typedef enum logic [1:0] {
    TUF_FL_IDLE,
    TUF_FL_ENCODE,
    TUF_FL_DRAIN,
    TUF_FL_ACK
  } tuf_flush_st_t;
endpackage

/* File: src/tuf_sync2.sv */
`timescale 1ns/1ps
module tuf_sync2 #(
  parameter int WIDTH = 1,
  parameter int STAGES = tuf_pkg::SYNC_STAGES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] stage_ff [STAGES];

  // only the next stage reads each stage, so metastability cannot fan out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_ff[i] <= '0;
      end
    end else begin
      stage_ff[0] <= d_i;
      for (int i = 1; i < STAGES; i++) begin
        stage_ff[i] <= stage_ff[i-1];
      end
    end
  end

  assign q_o = stage_ff[STAGES-1];
endmodule

/* File: src/tuf_byte_buf.sv */
`timescale 1ns/1ps
module tuf_byte_buf #(
  parameter int WIDTH = tuf_pkg::DATA_W,
  parameter int DEPTH = tuf_pkg::BUF_DEPTH,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic push_i,
  input wire logic [WIDTH-1:0] data_i,
  // drain side
  input wire logic pop_i,
  output logic [WIDTH-1:0] data_o,
  output logic [CNT_W-1:0] count_o
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] count_ff;

  // pointer wrap; depth need not be a power of two
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // storage; the caller never pushes when full nor pops when empty
  always_ff @(posedge clk_i) begin
    if (push_i) begin
      mem[wr_ptr_ff] <= data_i;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push_i) wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      if (pop_i) rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      count_ff <= count_ff + CNT_W'(push_i) - CNT_W'(pop_i);
    end
  end

  assign data_o = mem[rd_ptr_ff];
  assign count_o = count_ff;
endmodule

/* File: verification/tuf_cap_model.sv */
`timescale 1ns/1ps
// capture side: takes bytes under stall or slow ready, raises a flush on command
module tuf_cap_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // byte stream
  input wire logic valid_i,
  input wire logic [tuf_pkg::DATA_W-1:0] data_i,
  output logic ready_o,
  // bench controls
  input wire logic go_i,
  input wire logic stall_i,
  input wire logic slow_i,
  // flush handshake
  input wire logic ack_i,
  output logic req_o
);
  logic [tuf_pkg::DATA_W-1:0] got[$];
  int hold_n;

  // slow mode toggles ready so the unit meets back pressure mid burst
  always @(posedge clk_i) begin
    if (!rst_i && valid_i && ready_o) got.push_back(data_i);
    ready_o <= !rst_i && !stall_i && (!slow_i || !ready_o);
  end

  // request held past the answer for a few cycles, then withdrawn
  always @(posedge clk_i) begin
    if (rst_i) begin
      req_o <= 1'b0;
      hold_n <= 0;
    end else if (go_i && !req_o && !ack_i) begin
      req_o <= 1'b1;
    end else if (req_o && ack_i) begin
      hold_n <= hold_n + 1;
      if (hold_n == 3) req_o <= 1'b0;
    end else begin
      hold_n <= 0;
    end
  end
endmodule

/* File: verification/tb_tuf_trace_ctl.sv */
`timescale 1ns/1ps
// enable, flush and low power checks of the trace control block
module tb_tuf_trace_ctl;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pen = 1'b0, lock = 1'b0, ovr = 1'b0, wait_event_instr = 1'b0, wait_interrupt_instr = 1'b0, dbg = 1'b0;
  logic bar = 1'b0, proh = 1'b0, feat = 1'b0, bufen = 1'b0, ev = 1'b0, busy = 1'b0;
  logic ovf = 1'b0, epend = 1'b0, resb = 1'b0, go = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [7:0] ed = 8'h00;
  logic [3:0] evt = 4'h0;
  logic rdy, req, fack, ready, fl, gen, rrun, tval, en, idle, stab, lp, hold;
  logic [7:0] tdata;
  logic [3:0] xevt;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int checks_done = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  tuf_trace_ctl dut (
    .CLK_I(clk), .RST_I(rst), .PROGRAM_ENABLE_BIT_I(pen), .OS_LOCK_I(lock),
    .LOWPOWER_OVERRIDE_BIT_I(ovr), .PE_WAIT_EVENT_INSTR_I(wait_event_instr),
    .PE_WAIT_INTERRUPT_INSTR_I(wait_interrupt_instr), .PE_DEBUG_I(dbg), .TRACE_SYNC_BARRIER_I(bar),
    .TRACE_PROHIBITED_I(proh), .TRACE_BUFFER_FEATURE_I(feat), .TRACE_BUFFER_ENABLE_I(bufen),
    .ENC_VALID_I(ev), .ENC_DATA_I(ed), .ENC_BUSY_I(busy), .OVF_PENDING_I(ovf),
    .EVENT_ELEM_PENDING_I(epend), .ENC_READY_O(ready), .ENC_FLUSH_O(fl), .GEN_ENABLE_O(gen),
    .RES_BUSY_I(resb), .EVENT_I(evt), .RES_RUN_O(rrun), .EXTERNAL_EVENT_OUTPUT_O(xevt),
    .TRC_READY_I(rdy), .FLUSH_REQ_I(req), .TRC_VALID_O(tval), .TRC_DATA_O(tdata),
    .FLUSH_ACK_O(fack), .ENABLED_O(en), .STATUS_IDLE_FLAG_O(idle),
    .MODEL_STABLE_FLAG_O(stab), .LOWPOWER_O(lp), .LP_HOLDOFF_O(hold)
  );

  tuf_cap_model cap (
    .clk_i(clk), .rst_i(rst), .valid_i(tval), .data_i(tdata), .ready_o(rdy),
    .go_i(go), .stall_i(stall), .slow_i(slow), .ack_i(fack), .req_o(req)
  );

  // drives land by nba at rising edges, checks look at falling edges
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bounded wait, the caller compares afterwards so a hang shows as a mismatch
  task automatic await(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    @(negedge clk);
    while (s !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask

  // one encoder byte, held until the unit has room
  task automatic push(input logic [7:0] b);
    @(posedge clk);
    ev <= 1'b1;
    ed <= b;
    await(ready, 1'b1, 40);
    @(posedge clk);
    ev <= 1'b0;
    exp_q.push_back(b);
  endtask

  // capture side flush request through the model
  task automatic cflush();
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic cmpq();
    chk8("byte_count", 8'(exp_q.size()), 8'(cap.got.size()));
    foreach (exp_q[i]) chk8("byte", exp_q[i], cap.got[i]);
    exp_q.delete();
    cap.got.delete();
  endtask

  task automatic tdone(input string nm);
    $display("test %s done, mismatches so far %0d", nm, fail_count);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #400000;
    fail_count++;
    $display("FAIL watchdog expected finish seen hang");
    results();
  end

  initial begin
    cyc(4);
    rst <= 1'b0;
    @(negedge clk);
    chk1("enabled", 1'b0, en);
    chk1("idle", 1'b1, idle);
    chk1("stable", 1'b1, stab);
    tdone("reset");
    // override written while still disabled, before the first enable
    cyc(1);
    ovr <= 1'b0;
    // every combination of program enable and os lock
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      pen <= i[0];
      lock <= i[1];
      cyc(5);
      @(negedge clk);
      chk1("enabled", i[0] & ~i[1], en);
      chk1("gen_enable", i[0] & ~i[1], gen);
    end
    cyc(1);
    lock <= 1'b0;
    evt <= 4'ha;
    cyc(4);
    @(negedge clk);
    chk8("ext_event", 8'h0a, {4'h0, xevt});
    tdone("enable");
    // one byte more than the buffer holds, stalled, so the unit must refuse the next
    cyc(1);
    stall <= 1'b1;
    for (int n = 0; n <= tuf_pkg::BUF_DEPTH; n++) push(8'ha0 + 8'(n));
    stall <= 1'b0;
    slow <= 1'b1;
    @(negedge clk);
    chk1("enc_ready", 1'b0, ready);
    // capture flush under slow ready
    cflush();
    await(fack, 1'b1, 60);
    chk1("flush_ack", 1'b1, fack);
    cmpq();
    cyc(2);
    @(negedge clk);
    chk1("ack_held", 1'b1, fack);
    await(fack, 1'b0, 10);
    chk1("ack_drop", 1'b0, fack);
    tdone("capture_flush");
    // flush answer held back by overflow element, then by encoder work
    for (int k = 0; k < 2; k++) begin
      cyc(1);
      ovf <= (k == 0);
      busy <= (k == 1);
      cflush();
      cyc(8);
      @(negedge clk);
      chk1("ack_early", 1'b0, fack);
      chk1("enc_flush", 1'b1, fl);
      cyc(1);
      ovf <= 1'b0;
      busy <= 1'b0;
      await(fack, 1'b1, 40);
      chk1("flush_ack", 1'b1, fack);
      await(fack, 1'b0, 12);
    end
    tdone("flush_hold");
    // barrier in prohibited code flushes only with the buffer feature
    cyc(1);
    busy <= 1'b1;
    proh <= 1'b1;
    bufen <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      cyc(1);
      feat <= k[0];
      bar <= 1'b1;
      cyc(1);
      bar <= 1'b0;
      await(fl, 1'b1, 6);
      chk1("barrier_flush", k[0], fl);
    end
    cyc(1);
    busy <= 1'b0;
    cyc(10);
    tdone("barrier");
    // no cause keeps low power off; each cause allows it, override leaves it
    @(negedge clk);
    chk1("lowpower", 1'b0, lp);
    for (int k = 0; k < 3; k++) begin
      cyc(1);
      {dbg, wait_interrupt_instr, wait_event_instr} <= 3'h1 << k;
      await(lp, 1'b1, 12);
      chk1("lowpower", 1'b1, lp);
      chk1("enabled", 1'b1, en);
      chk1("gen_enable", 1'b0, gen);
      chk8("ext_event", 8'h00, {4'h0, xevt});
      cyc(1);
      ovr <= 1'b1;
      await(lp, 1'b0, 6);
      cyc(2);
      @(negedge clk);
      chk1("lowpower", 1'b0, lp);
      chk1("res_run", 1'b1, rrun);
      chk8("ext_event", 8'h0a, {4'h0, xevt});
      chk1("holdoff", 1'b0, hold);
      cyc(1);
      ovr <= 1'b0;
      {dbg, wait_interrupt_instr, wait_event_instr} <= 3'h0;
      cyc(6);
    end
    tdone("lowpower");
    // hold-off appears when enabled and busy, never once disabled
    wait_interrupt_instr <= 1'b1;
    busy <= 1'b1;
    await(hold, 1'b1, 8);
    chk1("holdoff", 1'b1, hold);
    cyc(1);
    pen <= 1'b0;
    cyc(4);
    @(negedge clk);
    chk1("holdoff", 1'b0, hold);
    chk1("enc_flush", 1'b1, fl);
    cyc(1);
    wait_interrupt_instr <= 1'b0;
    busy <= 1'b0;
    pen <= 1'b1;
    cyc(8);
    tdone("holdoff");
    // disable with bytes stalled, pending events and busy resources
    stall <= 1'b1;
    slow <= 1'b0;
    push(8'h11);
    push(8'h22);
    epend <= 1'b1;
    resb <= 1'b1;
    pen <= 1'b0;
    cyc(8);
    @(negedge clk);
    chk1("idle", 1'b0, idle);
    chk1("gen_enable", 1'b0, gen);
    chk1("res_run", 1'b0, rrun);
    chk8("ext_event", 8'h00, {4'h0, xevt});
    chk1("stable", 1'b0, stab);
    cyc(1);
    stall <= 1'b0;
    cyc(8);
    @(negedge clk);
    cmpq();
    chk1("idle", 1'b0, idle);
    cyc(1);
    epend <= 1'b0;
    await(idle, 1'b1, 10);
    chk1("idle", 1'b1, idle);
    cyc(1);
    resb <= 1'b0;
    // configuration touched only now that the unit is disabled and idle
    proh <= 1'b0;
    await(stab, 1'b1, 10);
    chk1("stable", 1'b1, stab);
    tdone("disable");
    results();
  end
endmodule
